/* File: sopm_pkg.sv */
package sopm_pkg;
   // register word indices; one word each, byte address is four times the index
   localparam logic [7:0] OFS_PIN0_CTRL = 8'h50;
   localparam logic [7:0] OFS_READBACK_CTRL = 8'h54;
   localparam logic [7:0] OFS_STATUS = 8'h58;
   localparam int NUM_PINS = 4;
   // field layout of a pin control byte
   localparam int BIT_DRV_ON = 0;
   localparam int BIT_DRV_STYLE = 1;
   localparam int SEL_LSB = 2;
   localparam int SEL_W = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] READBACK_MASK = 8'h03;
   // selector codes
   localparam logic [5:0] SEL_ALARM = 6'h00;
   localparam logic [5:0] SEL_SPI_DATA = 6'h01;
   localparam logic [5:0] SEL_LOS3 = 6'h02;
   localparam logic [5:0] SEL_LOS0 = 6'h05;
   localparam logic [5:0] SEL_HOLDOVER_ON = 6'h06;
   localparam logic [5:0] SEL_FIRST_LOCK = 6'h07;
   localparam logic [5:0] SEL_ACQUIRING = 6'h08;
   localparam logic [5:0] SEL_NEAR_LOCK = 6'h09;
   localparam logic [5:0] SEL_SECOND_LOCK = 6'h0a;
   localparam logic [5:0] SEL_NOT_SYNCED = 6'h0b;
   localparam logic [5:0] SEL_PHASE_STATUS = 6'h0c;
   localparam logic [5:0] SEL_BOTH_LOCK = 6'h0d;
   localparam logic [5:0] SEL_SYNC_REQ = 6'h0e;
   localparam logic [5:0] SEL_ACTIVE_REF0 = 6'h0f;
   localparam logic [5:0] SEL_ACTIVE_REF1 = 6'h10;
   localparam logic [5:0] SEL_ADC_RANGE = 6'h11;
   localparam logic [5:0] SEL_ADC_INPUT = 6'h12;
   localparam logic [5:0] SEL_XTAL = 6'h13;
   localparam logic [5:0] SEL_ACTIVE_REF = 6'h14;
   localparam logic [5:0] SEL_FSM_B0 = 6'h15;
   localparam logic [5:0] SEL_FSM_B2 = 6'h17;
   localparam logic [5:0] SEL_EXIT_B0 = 6'h18;
   localparam logic [5:0] SEL_EXIT_B1 = 6'h19;
   localparam logic [5:0] SEL_CHAN_BUSY = 6'h1a;
   localparam logic [5:0] SEL_SREF_B0 = 6'h1b;
   localparam logic [5:0] SEL_SREF_B3 = 6'h1e;
   localparam logic [5:0] SEL_FORCE_ONE = 6'h1f;
   localparam logic [5:0] SEL_FORCE_ZERO = 6'h20;
   localparam logic [5:0] SEL_AVG_B0 = 6'h27;
   localparam logic [5:0] SEL_AVG_B3 = 6'h2a;
   localparam logic [5:0] SEL_CUR_B0 = 6'h2b;
   localparam logic [5:0] SEL_CUR_B3 = 6'h2e;
   localparam logic [5:0] SEL_HOLD_CMP = 6'h3d;
   localparam logic [5:0] SEL_PULSE_REQ = 6'h3e;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* File: sopm_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bundle of asynchronous status levels
module sopm_sync2 #(
   parameter int W = 1
) (
   input wire logic ref_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic [W-1:0] async_in, // levels from other domains
   output logic [W-1:0] sync_out // synchronised levels
);
   logic [W-1:0] meta; // first stage, read only by second stage

   // two stages, nothing taps the first
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: sopm_pin_driver.sv */
`timescale 1ns/1ps
`default_nettype none
// converts a logic level plus style and enable into pad controls
module sopm_pin_driver (
   input wire logic ref_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic level, // value to present
   input wire logic drv_on, // driver enable
   input wire logic drv_style, // 0 open-drain, 1 push-pull
   output logic pad_out, // pad output value
   output logic pad_oe // pad output enable, high drives
);
   logic next_out; // combinational pad value
   logic next_oe; // combinational enable

   // open-drain only pulls low; push-pull drives both levels
   assign next_out = drv_style ? level : 1'b0;
   assign next_oe = drv_on & (drv_style | ~level);

   // registered so the pad never glitches on a selector change
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
      end else begin
         pad_out <= next_out;
         pad_oe <= next_oe;
      end
   end
endmodule
`default_nettype wire

/* File: sopm_status_output_pin_mux.sv */
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sopm_status_output_pin_mux #(
   parameter int NPINS = sopm_pkg::NUM_PINS
) (
   input wire logic ref_clk, // 250 mhz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   input wire logic alarm, // alarm level
   input wire logic spi_readback_data, // serial port readback bit
   input wire logic [3:0] ref_los, // loss of signal per reference input
   input wire logic holdover_on, // first loop in holdover
   input wire logic first_loop_lock, // first loop locked
   input wire logic acquiring, // first loop acquiring lock
   input wire logic near_lock, // first loop near lock
   input wire logic second_loop_lock, // second loop locked
   input wire logic not_synced, // sysref not synchronised since reset
   input wire logic phase_status, // clock outputs phase status
   input wire logic sync_request, // synchronisation request status
   input wire logic [1:0] active_ref_sel, // active reference flags 0/1
   input wire logic active_ref_status, // general active reference status
   input wire logic adc_range, // holdover adc input range status
   input wire logic adc_input, // holdover adc input status
   input wire logic crystal_oscillator_ok, // oscillator status
   input wire logic [2:0] first_loop_fsm, // first loop fsm state
   input wire logic [1:0] exit_phase, // holdover exit phase
   input wire logic chan_busy, // channel fsm busy
   input wire logic [3:0] sysref_fsm, // sysref fsm state
   input wire logic [3:0] dac_avg, // holdover converter averaged value
   input wire logic [3:0] dac_cur, // holdover converter present value
   input wire logic hold_cmp, // holdover comparator status
   input wire logic pulse_req, // pulse generator request status
   output logic [NPINS-1:0] status_output_pin_out, // pad values
   output logic [NPINS-1:0] status_output_pin_oe, // pad enables, high drives
   output logic serial_readback_pin_out, // readback pad value
   output logic serial_readback_pin_oe // readback pad enable, high drives
);
   localparam int NSRC = 40; // width of the source bundle

   // select one source by code; unlisted codes give zero
   function automatic logic pick(input logic [5:0] sel, input logic [NSRC-1:0] s);
      logic r;
      r = 1'b0;
      if (sel == sopm_pkg::SEL_ALARM) r = s[0];
      else if (sel == sopm_pkg::SEL_SPI_DATA) r = s[1];
      else if (sel >= sopm_pkg::SEL_LOS3 && sel <= sopm_pkg::SEL_LOS0)
         r = s[3'(2 + 3 - (sel - sopm_pkg::SEL_LOS3))];
      else if (sel == sopm_pkg::SEL_HOLDOVER_ON) r = s[6];
      else if (sel == sopm_pkg::SEL_FIRST_LOCK) r = s[7];
      else if (sel == sopm_pkg::SEL_ACQUIRING) r = s[8];
      else if (sel == sopm_pkg::SEL_NEAR_LOCK) r = s[9];
      else if (sel == sopm_pkg::SEL_SECOND_LOCK) r = s[10];
      else if (sel == sopm_pkg::SEL_NOT_SYNCED) r = s[11];
      else if (sel == sopm_pkg::SEL_PHASE_STATUS) r = s[12];
      else if (sel == sopm_pkg::SEL_BOTH_LOCK) r = s[7] & s[10];
      else if (sel == sopm_pkg::SEL_SYNC_REQ) r = s[13];
      else if (sel == sopm_pkg::SEL_ACTIVE_REF0) r = s[14];
      else if (sel == sopm_pkg::SEL_ACTIVE_REF1) r = s[15];
      else if (sel == sopm_pkg::SEL_ACTIVE_REF) r = s[16];
      else if (sel == sopm_pkg::SEL_ADC_RANGE) r = s[17];
      else if (sel == sopm_pkg::SEL_ADC_INPUT) r = s[18];
      else if (sel == sopm_pkg::SEL_XTAL) r = s[19];
      else if (sel >= sopm_pkg::SEL_FSM_B0 && sel <= sopm_pkg::SEL_FSM_B2)
         r = s[6'(20 + 6'(sel - sopm_pkg::SEL_FSM_B0))];
      else if (sel == sopm_pkg::SEL_EXIT_B0) r = s[23];
      else if (sel == sopm_pkg::SEL_EXIT_B1) r = s[24];
      else if (sel == sopm_pkg::SEL_CHAN_BUSY) r = s[25];
      else if (sel >= sopm_pkg::SEL_SREF_B0 && sel <= sopm_pkg::SEL_SREF_B3)
         r = s[6'(26 + 6'(sel - sopm_pkg::SEL_SREF_B0))];
      else if (sel == sopm_pkg::SEL_FORCE_ONE) r = 1'b1;
      else if (sel == sopm_pkg::SEL_FORCE_ZERO) r = 1'b0;
      else if (sel >= sopm_pkg::SEL_AVG_B0 && sel <= sopm_pkg::SEL_AVG_B3)
         r = s[6'(30 + 6'(sel - sopm_pkg::SEL_AVG_B0))];
      else if (sel >= sopm_pkg::SEL_CUR_B0 && sel <= sopm_pkg::SEL_CUR_B3)
         r = s[6'(34 + 6'(sel - sopm_pkg::SEL_CUR_B0))];
      else if (sel == sopm_pkg::SEL_HOLD_CMP) r = s[39];
      else if (sel == sopm_pkg::SEL_PULSE_REQ) r = s[38];
      else r = 1'b0;
      return r;
   endfunction

   // raw bundle, order fixed by the pick function above
   logic [NSRC-1:0] raw_src;
   logic [NSRC-1:0] src; // synchronised bundle
   assign raw_src = {hold_cmp, pulse_req, dac_cur, dac_avg, sysref_fsm, chan_busy,
      exit_phase, first_loop_fsm, crystal_oscillator_ok, adc_input, adc_range,
      active_ref_status, active_ref_sel, sync_request, phase_status, not_synced,
      second_loop_lock, near_lock, acquiring, first_loop_lock, holdover_on, ref_los,
      spi_readback_data, alarm};

   // status comes from other clock domains, so resync every bit
   sopm_sync2 #(.W(NSRC)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(raw_src),
      .sync_out(src)
   );

   // register storage
   logic [7:0] pin_ctrl [NPINS]; // per-pin control bytes
   logic [7:0] readback_ctrl; // readback pin control
   logic [NPINS-1:0] pin_level; // selected level per pin

   // ahb address phase capture
   logic ph_wr; // pending write data phase
   logic [7:0] ph_addr; // captured word index, pins and readback sit one word apart
   wire addr_ok = hsel & hready & htrans[1]; // valid address phase
   wire wr_take = addr_ok & hwrite & (hsize == sopm_pkg::HSIZE_WORD);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_wr <= 1'b0;
         ph_addr <= 8'h00;
      end else begin
         ph_wr <= wr_take;
         ph_addr <= addr_ok ? haddr[9:2] : ph_addr;
      end
   end

   // zero wait states; slave never errors
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // per-pin register, mux and driver
   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_pin
         wire [7:0] my_ofs = sopm_pkg::OFS_PIN0_CTRL + 8'(g);
         wire hit = ph_wr & (ph_addr == my_ofs);
         wire [5:0] sel = pin_ctrl[g][sopm_pkg::SEL_LSB +: sopm_pkg::SEL_W];

         // write lands in the data phase
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) pin_ctrl[g] <= sopm_pkg::CTRL_RESET;
            else if (hit) pin_ctrl[g] <= hwdata[7:0];
         end

         assign pin_level[g] = pick(sel, src);

         sopm_pin_driver u_drv (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .level(pin_level[g]),
            .drv_on(pin_ctrl[g][sopm_pkg::BIT_DRV_ON]),
            .drv_style(pin_ctrl[g][sopm_pkg::BIT_DRV_STYLE]),
            .pad_out(status_output_pin_out[g]),
            .pad_oe(status_output_pin_oe[g])
         );
      end
   endgenerate

   // readback pin control; reserved bits held at zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) readback_ctrl <= sopm_pkg::CTRL_RESET;
      else if (ph_wr && ph_addr == sopm_pkg::OFS_READBACK_CTRL)
         readback_ctrl <= hwdata[7:0] & sopm_pkg::READBACK_MASK;
   end

   // readback pin carries the serial port data
   sopm_pin_driver u_rb (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .level(src[1]),
      .drv_on(readback_ctrl[sopm_pkg::BIT_DRV_ON]),
      .drv_style(readback_ctrl[sopm_pkg::BIT_DRV_STYLE]),
      .pad_out(serial_readback_pin_out),
      .pad_oe(serial_readback_pin_oe)
   );

   // read mux, decoded at the address phase, registered for the data phase
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      for (int i = 0; i < NPINS; i++) begin
         if (haddr[9:2] == sopm_pkg::OFS_PIN0_CTRL + 8'(i))
            next_rdata = {24'h00_0000, pin_ctrl[i]};
      end
      if (haddr[9:2] == sopm_pkg::OFS_READBACK_CTRL)
         next_rdata = {24'h00_0000, readback_ctrl};
      if (haddr[9:2] == sopm_pkg::OFS_STATUS)
         next_rdata = {{(32 - NPINS){1'b0}}, pin_level};
   end

   // read data only refreshed on a read address phase
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) hrdata <= 32'h0000_0000;
      else if (addr_ok && !hwrite) hrdata <= next_rdata;
   end

   // checks
   wire [5:0] sel0 = pin_ctrl[0][sopm_pkg::SEL_LSB +: sopm_pkg::SEL_W];
   logic sync_request_q; // synchronised sync request, read only by a check
   assign sync_request_q = src[13];
   // pin 0 with its driver on and set to push-pull
   sequence s_pin0_drives_cmos;
      pin_ctrl[0][1:0] == 2'b11;
   endsequence
   // readback pin with its driver on and set to push-pull
   sequence s_rb_drives_cmos;
      readback_ctrl[1:0] == 2'b11;
   endsequence

   // routing; every pin shares the one pick function, so pin 0 stands for all
   chk_alarm_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_ALARM |-> pin_level[0] == src[0])
      else $error("alarm misrouted");
   chk_not_synced_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_NOT_SYNCED |-> pin_level[0] == src[11])
      else $error("not synced flag misrouted");
   chk_phase_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_PHASE_STATUS |-> pin_level[0] == src[12])
      else $error("phase status misrouted");
   chk_both_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_BOTH_LOCK |-> pin_level[0] == (src[7] & src[10]))
      else $error("both lock misrouted");
   chk_sync_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_SYNC_REQ |-> pin_level[0] == sync_request_q)
      else $error("sync request misrouted");
   chk_active_ref0: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_ACTIVE_REF0 |-> pin_level[0] == src[14])
      else $error("active reference 0 misrouted");
   chk_active_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_ACTIVE_REF |-> pin_level[0] == src[16])
      else $error("active reference status misrouted");
   chk_xtal_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_XTAL |-> pin_level[0] == src[19])
      else $error("oscillator status misrouted");
   chk_fsm_bit2: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_FSM_B2 |-> pin_level[0] == src[22])
      else $error("first loop fsm bit 2 misrouted");
   chk_exit_bit1: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_EXIT_B1 |-> pin_level[0] == src[24])
      else $error("exit phase bit 1 misrouted");
   chk_chan_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_CHAN_BUSY |-> pin_level[0] == src[25])
      else $error("channel busy misrouted");
   chk_sysref_bit3: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_SREF_B3 |-> pin_level[0] == src[29])
      else $error("sysref bit 3 misrouted");
   chk_avg_bit0: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_AVG_B0 |-> pin_level[0] == src[30])
      else $error("averaged bit misrouted");
   chk_cur_bit3: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_CUR_B3 |-> pin_level[0] == src[37])
      else $error("present value bit 3 misrouted");
   chk_hold_cmp: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_HOLD_CMP |-> pin_level[0] == src[39])
      else $error("comparator status misrouted");
   chk_pulse_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == sopm_pkg::SEL_PULSE_REQ |-> pin_level[0] == src[38])
      else $error("pulse request misrouted");

   // forced and reserved codes ignore every source
   chk_force_levels: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (sel0 == sopm_pkg::SEL_FORCE_ONE |-> pin_level[0])
      and (sel0 == sopm_pkg::SEL_FORCE_ZERO |-> !pin_level[0]))
      else $error("forced level wrong");
   chk_reserved_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sel0 == 6'h3f |-> !pin_level[0])
      else $error("reserved code not low");

   // register writes and pad drivers
   chk_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ph_wr && ph_addr == sopm_pkg::OFS_PIN0_CTRL |=> pin_ctrl[0] == $past(hwdata[7:0]))
      else $error("pin 0 control write lost");
   chk_cmos_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_pin0_drives_cmos ##0 $stable(pin_ctrl[0]) |=>
      status_output_pin_oe[0] && status_output_pin_out[0] == $past(pin_level[0]))
      else $error("cmos pin not following");
   chk_open_drain: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_output_pin_oe[0] && !$past(pin_ctrl[0][1]) |-> !status_output_pin_out[0])
      else $error("open drain drove high");
   chk_readback_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !readback_ctrl[0] |=> !serial_readback_pin_oe)
      else $error("readback driven while off");
   chk_readback_cmos: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_rb_drives_cmos ##0 $stable(readback_ctrl) |=>
      serial_readback_pin_oe && serial_readback_pin_out == $past(src[1]))
      else $error("readback pin not following");
endmodule
`default_nettype wire

/* File: sopm_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
// board side of the status pads: pull-ups on every line, levels sampled as seen
module sopm_board_model #(
   parameter int NPINS = 4
) (
   input wire logic [NPINS-1:0] pin_out, // pad values from the device
   input wire logic [NPINS-1:0] pin_oe, // pad enables, high drives
   input wire logic rb_out, // readback pad value
   input wire logic rb_oe, // readback pad enable, high drives
   output logic [NPINS-1:0] pin_level, // resolved wire levels
   output logic rb_level // resolved readback wire level
);
   // a released pad floats up to the pull-up, so an open-drain one reads high;
   // the last driven value is never kept, a stale low would hide a bad enable
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b1;
      end
      rb_level = rb_oe ? rb_out : 1'b1;
   end
endmodule
`default_nettype wire

/* File: status_output_pin_mux_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the status pin mux
module status_output_pin_mux_tb_top;
   localparam logic [7:0] IDX_PIN0 = 8'h50; // pin control index, pin g at +g
   localparam logic [7:0] IDX_READBACK = 8'h54; // readback control index
   localparam logic [7:0] IDX_UNMAPPED = 8'h60; // no register here
   localparam logic [7:0] IDX_STATUS = 8'h58; // selected levels, one bit per pin
   logic ref_clk = 1'b0; // bench clock
   logic rst_n = 1'b0; // async reset, active low
   logic hsel = 1'b0; // bus select
   logic [31:0] haddr = 32'h0; // bus address
   logic [1:0] htrans = 2'h0; // bus transfer type
   logic hwrite = 1'b0; // bus direction
   logic [2:0] hsize = 3'h0; // bus size
   logic [31:0] hwdata = 32'h0; // bus write data
   wire logic [31:0] hrdata; // bus read data
   wire logic hreadyout; // slave ready, also the bus ready
   wire logic hresp; // slave response
   logic [39:0] st = 40'h0; // all status sources, one slice each
   wire logic [3:0] pin_out, pin_oe, pin_lvl; // status pads and wire levels
   wire logic rb_out, rb_oe, rb_lvl; // readback pad and wire level
   int n_mismatch = 0; // mismatches seen
   int num_checks = 0; // comparisons made
   int seed = 47; // fixed seed keeps runs repeatable
   logic [31:0] rd; // last read data
   int p; // pin under test

   // 4 ns period
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   sopm_status_output_pin_mux u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .alarm(st[0]), .spi_readback_data(st[1]), .ref_los(st[5:2]), .holdover_on(st[6]),
      .first_loop_lock(st[7]), .acquiring(st[8]), .near_lock(st[9]),
      .second_loop_lock(st[10]), .not_synced(st[11]), .phase_status(st[12]),
      .sync_request(st[13]), .active_ref_sel(st[15:14]), .active_ref_status(st[16]),
      .adc_range(st[17]), .adc_input(st[18]), .crystal_oscillator_ok(st[19]),
      .first_loop_fsm(st[22:20]), .exit_phase(st[24:23]), .chan_busy(st[25]),
      .sysref_fsm(st[29:26]), .dac_avg(st[33:30]), .dac_cur(st[37:34]),
      .hold_cmp(st[38]), .pulse_req(st[39]), .status_output_pin_out(pin_out),
      .status_output_pin_oe(pin_oe), .serial_readback_pin_out(rb_out),
      .serial_readback_pin_oe(rb_oe));

   sopm_board_model u_board (.pin_out(pin_out), .pin_oe(pin_oe), .rb_out(rb_out),
      .rb_oe(rb_oe), .pin_level(pin_lvl), .rb_level(rb_lvl));

   // byte address of a register index, one word each
   function automatic logic [31:0] addr(input logic [7:0] idx);
      return {22'h0, idx, 2'b00};
   endfunction

   // level a selector code should put out, from the source slices
   function automatic logic exp_lvl(input logic [5:0] c, input logic [39:0] s);
      int i;
      i = int'(c);
      if (i <= 1 || (i >= 6 && i <= 12) || (i >= 17 && i <= 19)) return s[i];
      if (i >= 2 && i <= 5) return s[7 - i]; // loss flags run inputs 3 down to 0
      if (i == 13) return s[7] & s[10]; // both loops locked
      if ((i >= 14 && i <= 16) || (i >= 21 && i <= 30)) return s[i - 1];
      if (i == 20) return s[16];
      if (i == 31) return 1'b1;
      if (i >= 39 && i <= 46) return s[i - 9];
      if (i == 61) return s[38];
      if (i == 62) return s[39];
      return 1'b0; // force low and every reserved code
   endfunction

   // {out, oe, wire}: open-drain only ever pulls low
   function automatic logic [2:0] pad_exp(input logic on, input logic sty, input logic lvl);
      logic oe;
      oe = on & (sty | ~lvl);
      return {sty & lvl, oe, oe ? sty & lvl : 1'b1};
   endfunction

   // one single word transfer; holds each phase until ready is sampled high
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
         output logic [31:0] rd_o);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= sopm_pkg::HTRANS_NONSEQ;
      hsize <= sopm_pkg::HSIZE_WORD;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd_o = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask

   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one code on one pin: write, read back, pad level, then the status word
   task automatic sel_case(input logic [5:0] c, input int pin);
      logic e;
      ahb(1'b1, addr(IDX_PIN0 + 8'(pin)), {24'h0, c, 2'b11}, rd);
      st <= 40'({$random(seed), $random(seed)});
      ahb(1'b0, addr(IDX_PIN0 + 8'(pin)), 32'h0, rd);
      check(rd, {24'h0, c, 2'b11});
      repeat (5) @(posedge ref_clk);
      e = exp_lvl(c, st);
      check({30'h0, pin_oe[pin], pin_lvl[pin]}, {30'h0, 1'b1, e});
      ahb(1'b0, addr(IDX_STATUS), 32'h0, rd);
      check({31'h0, rd[pin]}, {31'h0, e});
   endtask

   // verdict and end of run
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // watchdog: the tests need about 1350 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      finish_test();
   end

   // main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      // reset values of the four pin registers and the readback register
      for (int g = 0; g < 5; g++) begin
         ahb(1'b0, addr(IDX_PIN0 + 8'(g)), 32'h0, rd);
         check(rd, {24'h0, sopm_pkg::CTRL_RESET});
      end
      $display("test reset values done");
      // every selector code on pin 0, and each code not a multiple of 4 again on pin c % 4, random sources
      for (int c = 0; c < 64; c++) begin
         sel_case(6'(c), 0);
         if (c % 4 != 0) sel_case(6'(c), c % 4);
      end
      $display("test selector sweep done");
      // driver enable and style with forced levels, both polarities
      for (int k = 0; k < 8; k++) begin
         p = k % 4;
         ahb(1'b1, addr(IDX_PIN0 + 8'(p)),
            {24'h0, k[2] ? sopm_pkg::SEL_FORCE_ONE : sopm_pkg::SEL_FORCE_ZERO, k[1], k[0]}, rd);
         repeat (3) @(posedge ref_clk);
         check({29'h0, pin_out[p], pin_oe[p], pin_lvl[p]}, {29'h0, pad_exp(k[0], k[1], k[2])});
      end
      $display("test driver style done");
      // readback register: reserved bits read zero, pad follows readback data
      ahb(1'b1, addr(IDX_READBACK), 32'hffff_ffff, rd);
      ahb(1'b0, addr(IDX_READBACK), 32'h0, rd);
      check(rd, 32'h0000_0003);
      for (int k = 0; k < 8; k++) begin
         st <= 40'({$random(seed), $random(seed)});
         ahb(1'b1, addr(IDX_READBACK), 32'(k % 4), rd);
         repeat (5) @(posedge ref_clk);
         check({29'h0, rb_out, rb_oe, rb_lvl}, {29'h0, pad_exp(k[0], k[1], st[1])});
      end
      $display("test readback pin done");
      // unmapped word: write ignored, reads zero
      ahb(1'b1, addr(IDX_UNMAPPED), 32'hffff_ffff, rd);
      ahb(1'b0, addr(IDX_UNMAPPED), 32'h0, rd);
      check(rd, 32'h0);
      $display("test unmapped address done");
      finish_test();
   end
endmodule
`default_nettype wire
